// *** mppg_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the parent answers read data combinationally from rd_idx.
module mppg_axil_slave
  import mppg_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Register side
  output logic                   wr_en,
  output logic [IDX_W-1:0]       wr_idx,
  output logic [7:0]             wr_data,
  output logic [IDX_W-1:0]       rd_idx,
  input  wire logic [7:0]        rd_data
);

  logic             aw_full_reg;
  logic             w_full_reg;
  logic             rd_pend_reg;
  logic [7:0]       w_byte_reg;
  logic             w_lane_reg;

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  // Address and data are taken in either order; response only once both are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      w_byte_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      wr_idx      <= '0;
      wr_data     <= 8'h00;
      wr_en       <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end
    else
    begin
      wr_en <= 1'b0;
      if (awvalid && awready)
      begin
        wr_idx      <= awaddr[ADDR_W-1:2];
        aw_full_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_byte_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
        w_full_reg <= 1'b1;
        wready     <= 1'b0;
      end
      if (aw_full_reg && w_full_reg && !bvalid)
      begin
        // A write without lane 0 changes nothing but still completes
        wr_en       <= w_lane_reg && mppg_mapped(wr_idx);
        wr_data     <= w_byte_reg;
        bresp       <= mppg_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        bvalid      <= 1'b1;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready     <= 1'b1;
      rd_pend_reg <= 1'b0;
      rd_idx      <= '0;
      rvalid      <= 1'b0;
      rdata       <= '0;
      rresp       <= RESP_OKAY;
    end
    else
    begin
      if (arvalid && arready)
      begin
        rd_idx      <= araddr[ADDR_W-1:2];
        rd_pend_reg <= 1'b1;
        arready     <= 1'b0;
      end
      if (rd_pend_reg)
      begin
        rdata       <= {24'h00_0000, rd_data};
        rresp       <= mppg_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        rvalid      <= 1'b1;
        rd_pend_reg <= 1'b0;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : mppg_axil_slave

// *** mppg_ctrl.sv ***
// Metering path control bank: two control registers, phase delay low bits,
// zero-crossing interrupt and a phase delay step counter.
// Assumes event and frame strobes come from logic on aclk.
module mppg_ctrl
  import mppg_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Metering events and inputs
  input  wire logic              zero_cross_event,
  input  wire logic              phase_frame_start,
  input  wire logic [2:0]        voltage_gain_exponent,
  // Datapath settings
  output logic                   rms_bandpass_enable,
  output logic signed [3:0]      voltage_gain_log2,
  output logic                   e2_active_from_i2,
  output logic                   e2_reactive_invert,
  output logic                   i2_gain_sign,
  output logic [2:0]             i2_gain_log2,
  output logic                   phase_delay_voltage,
  output logic [7:0]             phase_delay_steps,
  // Phase delay progress
  output logic                   phase_delay_busy,
  output logic                   phase_delay_done,
  // Interrupt
  output logic                   irq
);

  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0]       wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_data;
  logic [7:0]       ctrl3_reg;
  logic [7:0]       phase1_reg;
  logic [1:0]       delay_low_reg;
  logic             irq_stat_reg;
  logic             irq_en_reg;
  logic [6:0]       sample_cnt_reg;
  logic             sample_tick_reg;
  logic [7:0]       step_cnt_reg;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  mppg_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl3_reg     <= CTRL3_RST;
      phase1_reg    <= PHASE1_RST;
      delay_low_reg <= DLY_LOW_RST;
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_CTRL3)
        ctrl3_reg <= wr_data;
      if (wr_idx == IDX_PHASE1)
        phase1_reg <= wr_data & ~(8'h01 << PH_UNUSED);
      if (wr_idx == IDX_NOLOAD)
        delay_low_reg <= wr_data[DLY_LO_MSB:0];
    end
  end

  // Reserved bits of every register read as zero
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_idx)
      IDX_CTRL3:    rd_data = ctrl3_reg;
      IDX_PHASE1:   rd_data = phase1_reg;
      IDX_NOLOAD:   rd_data = {6'h00, delay_low_reg};
      IDX_IRQ_STAT: rd_data = {7'h00, irq_stat_reg};
      IDX_IRQ_EN:   rd_data = {7'h00, irq_en_reg};
      default:      rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Status always records events; the enable and the control bit only gate the line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= IRQ_RST;
      irq_en_reg   <= IRQ_RST;
      irq          <= 1'b0;
    end
    else
    begin
      // A new event beats a clear in the same cycle
      if (zero_cross_event)
        irq_stat_reg <= 1'b1;
      else if (wr_en && wr_idx == IDX_IRQ_CLR && wr_data[IRQ_ZC])
        irq_stat_reg <= 1'b0;
      if (wr_en && wr_idx == IDX_IRQ_EN)
        irq_en_reg <= wr_data[IRQ_ZC];
      irq <= irq_stat_reg && irq_en_reg && ctrl3_reg[BIT_ZC_EN];
    end
  end

  // ----------------------------------------
  // Decoded settings
  // ----------------------------------------
  mppg_path_decode u_decode (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .ctrl3                 (ctrl3_reg),
    .phase1                (phase1_reg),
    .delay_low             (delay_low_reg),
    .voltage_gain_exponent (voltage_gain_exponent),
    .rms_bandpass_on       (rms_bandpass_enable),
    .voltage_gain_log2     (voltage_gain_log2),
    .e2_active_i2          (e2_active_from_i2),
    .e2_reactive_invert    (e2_reactive_invert),
    .i2_gain_negative      (i2_gain_sign),
    .i2_gain_log2          (i2_gain_log2),
    .delay_voltage         (phase_delay_voltage),
    .phase_delay           (phase_delay_steps)
  );

  // ----------------------------------------
  // Compensation sample tick
  // ----------------------------------------
  // Integer divider: the step runs slightly fast, 61 cycles against 61.04
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_cnt_reg  <= 7'h00;
      sample_tick_reg <= 1'b0;
    end
    else
    begin
      sample_tick_reg <= (sample_cnt_reg == 7'(SAMPLE_CYC - 1));
      sample_cnt_reg  <= (sample_cnt_reg == 7'(SAMPLE_CYC - 1)) ? 7'h00 : sample_cnt_reg + 7'h01;
    end
  end

  // ----------------------------------------
  // Phase delay step counter
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_cnt_reg     <= 8'h00;
      phase_delay_busy <= 1'b0;
      phase_delay_done <= 1'b0;
    end
    else
    begin
      phase_delay_done <= 1'b0;
      if (phase_frame_start)
      begin
        step_cnt_reg     <= phase_delay_steps;
        phase_delay_busy <= (phase_delay_steps != 8'h00);
        phase_delay_done <= (phase_delay_steps == 8'h00);
      end
      else if (phase_delay_busy && sample_tick_reg)
      begin
        step_cnt_reg <= step_cnt_reg - 8'h01;
        if (step_cnt_reg == 8'h01)
        begin
          phase_delay_busy <= 1'b0;
          phase_delay_done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ctrl3_wr;
    wr_en && wr_idx == IDX_CTRL3;
  endsequence

  sequence s_phase_wr;
    wr_en && wr_idx == IDX_PHASE1;
  endsequence

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      irq |-> $past(ctrl3_reg[BIT_ZC_EN] && irq_en_reg && irq_stat_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_reset_mask;
    @(posedge aclk) !aresetn |=> (ctrl3_reg == CTRL3_RST && phase1_reg == PHASE1_RST && !irq);
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("reset value wrong");

  property p_bpf;
    @(posedge aclk) disable iff (!aresetn)
      s_ctrl3_wr ##1 !wr_en |=> rms_bandpass_enable == $past(wr_data[BIT_BPF], 2);
  endproperty
  a_bpf: assert property (p_bpf) else $error("band-pass not applied");

  property p_vgain;
    @(posedge aclk) disable iff (!aresetn)
      $stable(ctrl3_reg) && $stable(voltage_gain_exponent) && voltage_gain_exponent <= 3'h5
      |=> voltage_gain_log2 == ($past(ctrl3_reg[BIT_VQ])
          ? $signed({1'b0, $past(voltage_gain_exponent)}) - 4'sh2
          : $signed({1'b0, $past(voltage_gain_exponent)}));
  endproperty
  a_vgain: assert property (p_vgain) else $error("voltage gain wrong");

  property p_e2_mode;
    @(posedge aclk) disable iff (!aresetn)
      ##1 (e2_active_from_i2 == $past(ctrl3_reg[BIT_E2SEL]))
        && (e2_reactive_invert == !e2_active_from_i2);
  endproperty
  a_e2_mode: assert property (p_e2_mode) else $error("second path mode wrong");

  property p_i2_gain;
    @(posedge aclk) disable iff (!aresetn)
      ##1 i2_gain_log2 <= 3'h5 && i2_gain_sign == $past(ctrl3_reg[BIT_I2NEG])
        && ($past(ctrl3_reg[2:0]) > 3'h5 || i2_gain_log2 == $past(ctrl3_reg[2:0]));
  endproperty
  a_i2_gain: assert property (p_i2_gain) else $error("i2 gain wrong");

  property p_phase_word;
    @(posedge aclk) disable iff (!aresetn)
      s_phase_wr ##1 !wr_en |=> phase_delay_steps[7:2] == $past(wr_data[5:0], 2)
        && phase_delay_voltage == $past(wr_data[7], 2);
  endproperty
  a_phase_word: assert property (p_phase_word) else $error("phase delay word wrong");

  property p_unused_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_phase_wr |=> !phase1_reg[PH_UNUSED];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit stored");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      phase_delay_busy && sample_tick_reg && !phase_frame_start
      |=> step_cnt_reg == $past(step_cnt_reg) - 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("delay step missed");

  property p_done_at_zero;
    @(posedge aclk) disable iff (!aresetn)
      phase_delay_done |-> !phase_delay_busy && step_cnt_reg == 8'h00;
  endproperty
  a_done_at_zero: assert property (p_done_at_zero) else $error("done early");

endmodule : mppg_ctrl

// *** mppg_ctrl_tb_top.sv ***
// Self-checking bench for the metering path control bank.
// Assumes mppg_pkg and mppg_ctrl are compiled first; the bench drives every port itself.
module mppg_ctrl_tb_top
  import mppg_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'h0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              zc_ev = 1'b0, frame = 1'b0;
  logic [2:0]        vexp = 3'h0;
  logic              bpf, e2_act, e2_inv, i2_neg, dly_v, busy, done, irq;
  logic signed [3:0] vlog2;
  logic [2:0]        i2log2;
  logic [7:0]        steps;
  logic [1:0]        rsp;
  logic [31:0]       rd;
  int                bad_count = 0, checks_done = 0, cycles = 0;

  always #2.5 aclk = ~aclk;

  mppg_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .zero_cross_event(zc_ev), .phase_frame_start(frame), .voltage_gain_exponent(vexp),
    .rms_bandpass_enable(bpf), .voltage_gain_log2(vlog2), .e2_active_from_i2(e2_act),
    .e2_reactive_invert(e2_inv), .i2_gain_sign(i2_neg), .i2_gain_log2(i2log2),
    .phase_delay_voltage(dly_v), .phase_delay_steps(steps),
    .phase_delay_busy(busy), .phase_delay_done(done), .irq(irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Address and data are offered together and each released at its own take
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] exp_resp);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the bench timeout ends a wait on the slave
    while (!(a && w))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do
      @(posedge aclk);
    while (!bvalid);
    check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp,
                        input logic [1:0] exp_resp);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (!arready);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!rvalid);
    check("rdata", rdata, {24'h00_0000, exp});
    check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
    rready <= 1'b0;
  endtask : rd_chk

  // Settings lag the register by one cycle
  task automatic settle();
    repeat (4) @(posedge aclk);
    #1;
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset(input string tag);
    #1;
    check({tag, " irq"}, irq, 1'b0);
    check({tag, " e2_inv"}, e2_inv, 1'b1);
    rd_chk(IDX_CTRL3, CTRL3_RST, RESP_OKAY);
    rd_chk(IDX_PHASE1, PHASE1_RST, RESP_OKAY);
    rd_chk(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    rd_chk(IDX_IRQ_EN, 8'h00, RESP_OKAY);
  endtask : t_reset

  task automatic t_ctrl3();
    vexp <= 3'h3;
    wr(IDX_CTRL3, 8'h7e, 4'hf, RESP_OKAY);
    settle();
    check("bpf on", bpf, 1'b1);
    check("vgain quarter", {28'h0, vlog2}, 32'h0000_0001);
    check("e2 active", e2_act, 1'b1);
    check("e2 inv off", e2_inv, 1'b0);
    check("i2 neg", i2_neg, 1'b1);
    check("i2 clamp", {29'h0, i2log2}, 32'h0000_0005);
    rd_chk(IDX_CTRL3, 8'h7e, RESP_OKAY);
    vexp <= 3'h5;
    wr(IDX_CTRL3, 8'h04, 4'hf, RESP_OKAY);
    settle();
    check("bpf off", bpf, 1'b0);
    check("vgain full", {28'h0, vlog2}, 32'h0000_0005);
    check("e2 reactive", e2_act, 1'b0);
    check("e2 inv on", e2_inv, 1'b1);
    check("i2 pos", i2_neg, 1'b0);
    check("i2 gain", {29'h0, i2log2}, 32'h0000_0004);
    // Strobe on lane zero off: answered but ignored
    wr(IDX_CTRL3, 8'hff, 4'he, RESP_OKAY);
    rd_chk(IDX_CTRL3, 8'h04, RESP_OKAY);
    wr(14'h0000, 8'h11, 4'hf, RESP_SLVERR);
    rd_chk(14'h0000, 8'h00, RESP_SLVERR);
  endtask : t_ctrl3

  task automatic t_phase();
    int t;
    wr(IDX_NOLOAD, 8'h02, 4'hf, RESP_OKAY);
    wr(IDX_PHASE1, 8'hff, 4'hf, RESP_OKAY);
    rd_chk(IDX_PHASE1, 8'hbf, RESP_OKAY);
    settle();
    check("delay voltage", dly_v, 1'b1);
    check("steps max", {24'h00_0000, steps}, 32'h0000_00fe);
    wr(IDX_PHASE1, 8'h40, 4'hf, RESP_OKAY);
    rd_chk(IDX_PHASE1, 8'h00, RESP_OKAY);
    settle();
    check("delay i1", dly_v, 1'b0);
    check("steps low", {24'h00_0000, steps}, 32'h0000_0002);
    @(posedge aclk);
    frame <= 1'b1;
    @(posedge aclk);
    frame <= 1'b0;
    for (t = 0; t < 400; t++)
    begin
      @(posedge aclk);
      #1;
      if (done === 1'b1) break;
      if (t == 1) check("busy", busy, 1'b1);
    end
    // Two steps at one tick each, tick phase free running
    check("step time", (t >= SAMPLE_CYC && t <= 2 * SAMPLE_CYC + 2), 1'b1);
    @(posedge aclk);
    #1;
    check("busy off", busy, 1'b0);
    check("done pulse", done, 1'b0);
    // A zero delay word finishes at once
    wr(IDX_NOLOAD, 8'h00, 4'hf, RESP_OKAY);
    settle();
    @(posedge aclk);
    frame <= 1'b1;
    @(posedge aclk);
    frame <= 1'b0;
    #1;
    check("done at zero", done, 1'b1);
    check("idle at zero", busy, 1'b0);
  endtask : t_phase

  task automatic t_irq();
    wr(IDX_IRQ_EN, 8'h01, 4'hf, RESP_OKAY);
    @(posedge aclk);
    zc_ev <= 1'b1;
    @(posedge aclk);
    zc_ev <= 1'b0;
    settle();
    check("irq masked", irq, 1'b0);
    rd_chk(IDX_IRQ_STAT, 8'h01, RESP_OKAY);
    wr(IDX_CTRL3, 8'h84, 4'hf, RESP_OKAY);
    settle();
    check("irq raised", irq, 1'b1);
    wr(IDX_IRQ_CLR, 8'h01, 4'hf, RESP_OKAY);
    settle();
    check("irq cleared", irq, 1'b0);
    rd_chk(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
  endtask : t_irq

  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset("por");
    t_ctrl3();
    t_phase();
    t_irq();
    wr(IDX_PHASE1, 8'h3f, 4'hf, RESP_OKAY);
    // Raise the interrupt so the mid-run reset has something to clear
    zc_ev <= 1'b1;
    @(posedge aclk);
    zc_ev <= 1'b0;
    settle();
    check("irq before reset", irq, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset("mid");
    end_of_test();
  end

endmodule : mppg_ctrl_tb_top

// *** mppg_path_decode.sv ***
// Turns the control fields into registered gain and delay settings.
// Assumes all inputs come from flip-flops on the same clock.
module mppg_path_decode
  import mppg_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control fields
  input  wire logic [7:0] ctrl3,
  input  wire logic [7:0] phase1,
  input  wire logic [1:0] delay_low,
  input  wire logic [2:0] voltage_gain_exponent,
  // Decoded settings
  output logic            rms_bandpass_on,
  output logic signed [3:0] voltage_gain_log2,
  output logic            e2_active_i2,
  output logic            e2_reactive_invert,
  output logic            i2_gain_negative,
  output logic [2:0]      i2_gain_log2,
  output logic            delay_voltage,
  output logic [7:0]      phase_delay
);

  logic [2:0] v_exp;
  logic [2:0] i2_exp;

  // Out-of-range exponents are held at the largest legal setting
  assign v_exp  = (voltage_gain_exponent > GAIN_EXP_MAX) ? GAIN_EXP_MAX : voltage_gain_exponent;
  assign i2_exp = (ctrl3[I2EXP_MSB:0] > GAIN_EXP_MAX) ? GAIN_EXP_MAX : ctrl3[I2EXP_MSB:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rms_bandpass_on    <= 1'b0;
      voltage_gain_log2  <= 4'sh0;
      e2_active_i2       <= 1'b0;
      e2_reactive_invert <= 1'b1;
      i2_gain_negative   <= 1'b0;
      i2_gain_log2       <= 3'h0;
      delay_voltage      <= 1'b0;
      phase_delay        <= 8'h00;
    end
    else
    begin
      rms_bandpass_on <= ctrl3[BIT_BPF];
      // Quarter gain is two less in the exponent
      voltage_gain_log2 <= ctrl3[BIT_VQ] ? $signed({1'b0, v_exp}) - $signed(QUARTER_SHIFT)
                                         : $signed({1'b0, v_exp});
      e2_active_i2       <= ctrl3[BIT_E2SEL];
      e2_reactive_invert <= !ctrl3[BIT_E2SEL];
      i2_gain_negative   <= ctrl3[BIT_I2NEG];
      i2_gain_log2       <= i2_exp;
      delay_voltage      <= phase1[PH_TARGET];
      phase_delay        <= {phase1[PH_HI_MSB:0], delay_low};
    end
  end

endmodule : mppg_path_decode

// *** mppg_pkg.sv ***
// Constants, register map and field layout of the metering path control bank.
// Assumes a single 200 MHz clock and a 32-bit AXI4-Lite register bus.
package mppg_pkg;

  // ----------------------------------------
  // Bus geometry and register indices
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;
  localparam logic [IDX_W-1:0] IDX_CTRL3    = 14'h287a;
  localparam logic [IDX_W-1:0] IDX_PHASE1   = 14'h287b;
  localparam logic [IDX_W-1:0] IDX_NOLOAD   = 14'h287f;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 14'h2880;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 14'h2881;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 14'h2882;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] CTRL3_RST   = 8'h00;
  localparam logic [7:0] PHASE1_RST  = 8'h00;
  localparam logic [1:0] DLY_LOW_RST = 2'h0;
  localparam logic       IRQ_RST     = 1'b0;
  localparam int BIT_ZC_EN  = 7;
  localparam int BIT_BPF    = 6;
  localparam int BIT_VQ     = 5;
  localparam int BIT_E2SEL  = 4;
  localparam int BIT_I2NEG  = 3;
  localparam int I2EXP_MSB  = 2;
  localparam int PH_TARGET  = 7;
  localparam int PH_UNUSED  = 6;
  localparam int PH_HI_MSB  = 5;
  localparam int DLY_LO_MSB = 1;
  localparam int IRQ_ZC     = 0;

  // ----------------------------------------
  // Gains and phase step timing
  // ----------------------------------------
  localparam logic [2:0] GAIN_EXP_MAX  = 3'h5;
  localparam logic [3:0] QUARTER_SHIFT = 4'h2;
  localparam real CLK_MHZ     = 200.0;
  localparam real COMP_FS_MHZ = 3.2768;
  localparam real STEP_DEG    = 0.0055;
  localparam real RANGE_DEG   = 1.4;
  localparam int  SAMPLE_CYC  = $rtoi(CLK_MHZ / COMP_FS_MHZ);

  function automatic logic mppg_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_CTRL3) || (idx == IDX_PHASE1) || (idx == IDX_NOLOAD) ||
           (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_EN);
  endfunction : mppg_mapped

endpackage : mppg_pkg
